/* fmr_consts.vh */
`ifndef FMR_CONSTS_VH
`define FMR_CONSTS_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define FMR_IDX_ALPHA_CURRENT            12'h04D2
`define FMR_IDX_BETA_CURRENT             12'h04D4
`define FMR_IDX_ALPHA_VOLTAGE            12'h04D6
`define FMR_IDX_BETA_VOLTAGE             12'h04D8
`define FMR_IDX_DIRECT_AXIS_CURRENT      12'h04E2
`define FMR_IDX_QUADRATURE_AXIS_CURRENT  12'h04E4
`define FMR_IDX_DIRECT_AXIS_VOLTAGE      12'h04E6
`define FMR_IDX_QUADRATURE_AXIS_VOLTAGE  12'h04E8
`define FMR_IDX_ALIGN_CURRENT_TARGET     12'h0524
`define FMR_IDX_HANDOVER_SPEED_TARGET    12'h053C
`define FMR_IDX_STARTUP_CURRENT_TARGET   12'h054C
`define FMR_IDX_SPEED_LOOP_TARGET        12'h05D2
// ----------------------------------------
// Widths, reset, encodings
// ----------------------------------------
`define FMR_NUM_REGS      12
`define FMR_SEL_W         4
`define FMR_ADDR_W        14
`define FMR_DATA_W        32
`define FMR_FRAC_BITS     27
`define FMR_RESET_VALUE   32'h0000_0000
`define FMR_RESP_OKAY     2'h0
`define FMR_RESP_SLVERR   2'h2
`endif

/* fmr_regmem.v */
`timescale 1ns/100ps
`include "fmr_consts.vh"
module fmr_regmem (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        wr_en,
    input  wire [3:0]  wr_sel,
    input  wire [31:0] wr_data,
    input  wire [3:0]  rd_sel,
    output reg  [31:0] rd_data
);
    reg [31:0] mem_q [0:`FMR_NUM_REGS-1];
    genvar g;
    // ----------------------------------------
    // Storage, cleared by reset
    // ----------------------------------------
    generate
        for (g = 0; g < `FMR_NUM_REGS; g = g + 1) begin : g_word
            always @(posedge core_clk) begin
                if (srst) begin
                    mem_q[g] <= `FMR_RESET_VALUE;
                end else if (wr_en && wr_sel == g) begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate
    always @(posedge core_clk) begin
        if (srst) begin
            rd_data <= `FMR_RESET_VALUE;
        end else if (rd_sel < `FMR_NUM_REGS) begin
            rd_data <= mem_q[rd_sel];
        end else begin
            rd_data <= `FMR_RESET_VALUE;
        end
    end
endmodule

/* fmr_monitor.v */
// Overview of operation
// - Twelve 32-bit read-only words, zero after reset
// - Alpha current, Q27 times base current over 8
// - Beta current, Q27 times base current over 8
// - Alpha voltage, Q27 times 60 over root3
// - Beta voltage, Q27 times 60 over root3
// - Direct current, Q27 times base current over 8
// - Quadrature current, Q27 base current over 8
// - Direct voltage, Q27 times 60 over root3
// - Quadrature voltage, Q27 times 60 over root3
// - Align current target, Q27 base current/8
// - Handover speed, Q27 times maximum speed Hz
// - Startup current target, Q27 base current/8
// - Speed loop target, Q27 times maximum speed
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fmr_consts.vh"
module fmr_monitor (
    core_clk,
    srst,
    upd_valid,
    upd_sel,
    upd_data,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input  wire        core_clk;
    input  wire        srst;
    input  wire        upd_valid;
    input  wire [3:0]  upd_sel;
    input  wire [31:0] upd_data;
    input  wire [13:0] s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [13:0] s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output wire [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;

    localparam [1:0] RD_IDLE = 2'b00;
    localparam [1:0] RD_LOOK = 2'b01;
    localparam [1:0] RD_RESP = 2'b10;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Returns register select, or 4'hF when unmapped or misaligned.
    function [3:0] fmr_decode;
        input [13:0] addr;
        begin
            if (addr[1:0] != 2'b00) begin
                fmr_decode = 4'hF;
            end else begin
                case (addr[13:2])
                    `FMR_IDX_ALPHA_CURRENT:           fmr_decode = 4'h0;
                    `FMR_IDX_BETA_CURRENT:            fmr_decode = 4'h1;
                    `FMR_IDX_ALPHA_VOLTAGE:           fmr_decode = 4'h2;
                    `FMR_IDX_BETA_VOLTAGE:            fmr_decode = 4'h3;
                    `FMR_IDX_DIRECT_AXIS_CURRENT:     fmr_decode = 4'h4;
                    `FMR_IDX_QUADRATURE_AXIS_CURRENT: fmr_decode = 4'h5;
                    `FMR_IDX_DIRECT_AXIS_VOLTAGE:     fmr_decode = 4'h6;
                    `FMR_IDX_QUADRATURE_AXIS_VOLTAGE: fmr_decode = 4'h7;
                    `FMR_IDX_ALIGN_CURRENT_TARGET:    fmr_decode = 4'h8;
                    `FMR_IDX_HANDOVER_SPEED_TARGET:   fmr_decode = 4'h9;
                    `FMR_IDX_STARTUP_CURRENT_TARGET:  fmr_decode = 4'hA;
                    `FMR_IDX_SPEED_LOOP_TARGET:       fmr_decode = 4'hB;
                    default:                          fmr_decode = 4'hF;
                endcase
            end
        end
    endfunction

    // ----------------------------------------
    // Write channel: accept, discard, answer
    // ----------------------------------------
    reg        aw_seen_q;
    reg        w_seen_q;
    wire       aw_take;
    wire       w_take;
    wire       aw_now;
    wire       w_now;

    assign s_axi_awready = !aw_seen_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_seen_q && !s_axi_bvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign aw_now        = aw_seen_q || aw_take;
    assign w_now         = w_seen_q || w_take;

    always @(posedge core_clk) begin
        if (srst) begin
            aw_seen_q    <= 1'b0;
            w_seen_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FMR_RESP_OKAY;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (aw_now && w_now) begin
            // Data dropped: the bank is read-only to software
            aw_seen_q    <= 1'b0;
            w_seen_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Mapped read-only words answer SLVERR, unmapped too
            s_axi_bresp  <= `FMR_RESP_SLVERR;
        end else begin
            if (aw_take) begin
                aw_seen_q <= 1'b1;
            end
            if (w_take) begin
                w_seen_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    reg  [1:0]  rd_state_q;
    reg  [3:0]  rd_sel_q;
    wire [3:0]  mem_rd_sel;
    wire [31:0] mem_rd_data;
    reg  [31:0] rdata_q;

    assign s_axi_arready = (rd_state_q == RD_IDLE);
    // Look up on the address beat, then latch once: the answer stands
    // unchanged through any rready stall, even while updates arrive
    assign mem_rd_sel    = (rd_state_q == RD_IDLE) ?
                           fmr_decode(s_axi_araddr) : rd_sel_q;
    assign s_axi_rdata   = rdata_q;

    always @(posedge core_clk) begin
        if (srst) begin
            rd_state_q   <= RD_IDLE;
            rd_sel_q     <= 4'h0;
            rdata_q      <= `FMR_RESET_VALUE;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `FMR_RESP_OKAY;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_sel_q   <= fmr_decode(s_axi_araddr);
                        rd_state_q <= RD_LOOK;
                    end
                end
                RD_LOOK: begin
                    // Unmapped reads return zero data with an error response
                    rdata_q      <= (rd_sel_q == 4'hF) ?
                                    `FMR_RESET_VALUE : mem_rd_data;
                    s_axi_rresp  <= (rd_sel_q == 4'hF) ?
                                    `FMR_RESP_SLVERR : `FMR_RESP_OKAY;
                    s_axi_rvalid <= 1'b1;
                    rd_state_q   <= RD_RESP;
                end
                RD_RESP: begin
                    // Plain read, no side effect on the word
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state_q   <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q   <= RD_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Update port from the control algorithm
    // ----------------------------------------
    // Values arrive already in signed Q27 in the scales below:
    // 0,1,4,5 currents x base/8
    wire upd_ok;
    // Voltages 2,3,6,7 use 60/sqrt(3); targets 8,A base/8; 9,B speed
    assign upd_ok = upd_valid && (upd_sel < `FMR_NUM_REGS);
    // Q27 full scale stored verbatim, no rescaling inside the bank

    fmr_regmem u_mem (
        .core_clk (core_clk),
        .srst     (srst),
        .wr_en    (upd_ok),
        .wr_sel   (upd_sel),
        .wr_data  (upd_data),
        .rd_sel   (mem_rd_sel),
        .rd_data  (mem_rd_data)
    );
endmodule

/* fmr_monitor_checker.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Bus handshake checks
// ----------------------------------------
module fmr_checker (
    input wire        core_clk,
    input wire        srst,
    input wire        upd_valid,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_rd_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer not two cycles after address");
    a_rd_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed while stalled");
    a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted while answer pending");
    a_rd_ends: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not cleared after handshake");
    a_wr_refused: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h2)
        else $error("write not answered with slave error");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid [*1] ##0 !s_axi_awready && !s_axi_wready)
        else $error("write answer missing or channels still open");
    a_wr_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped while stalled");
    a_reset_idle: assert property (disable iff (1'h0)
        srst |=> !s_axi_rvalid && !s_axi_bvalid && s_axi_arready)
        else $error("bus not idle after reset");
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_update: cover property (upd_valid);
    c_rd_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind fmr_monitor fmr_checker u_chk (.core_clk, .srst, .upd_valid,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* test_foc_monitor_registers.sv */
`timescale 1ns/100ps
module test_foc_monitor_registers;
    reg         core_clk = 1'h0;
    reg         srst = 1'h1;
    reg         upd_valid = 1'h0;
    reg  [3:0]  upd_sel = 4'h0;
    reg  [31:0] upd_data = 32'h0000_0000;
    reg  [13:0] s_axi_awaddr = 14'h0000;
    reg  [13:0] s_axi_araddr = 14'h0000;
    reg  [31:0] s_axi_wdata = 32'h0000_0000;
    reg  [3:0]  s_axi_wstrb = 4'hf;
    reg         s_axi_awvalid = 1'h0;
    reg         s_axi_wvalid = 1'h0;
    reg         s_axi_bready = 1'h0;
    reg         s_axi_arvalid = 1'h0;
    reg         s_axi_rready = 1'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     failures = 0;
    integer     num_checks = 0;
    integer     i;
    // Word index of each register; byte address is four times it
    reg  [11:0] idx [0:11] = '{12'h04d2, 12'h04d4, 12'h04d6, 12'h04d8,
        12'h04e2, 12'h04e4, 12'h04e6, 12'h04e8, 12'h0524, 12'h053c,
        12'h054c, 12'h05d2};

    always #4 core_clk = ~core_clk;

    fmr_monitor DUT (.core_clk, .srst, .upd_valid, .upd_sel, .upd_data,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    function [31:0] val(input integer k);
        val = {k[3:0], 28'h9b7_3e51};
    endfunction

    task chk(input [255:0] n, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("ERROR %0s expected %h seen %h", n, e, g);
            end
        end
    endtask

    task rc(input [13:0] a, input [31:0] e, input [1:0] er);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            @(posedge core_clk);
            while (s_axi_arready !== 1'h1) @(posedge core_clk);
            s_axi_arvalid <= 1'h0;
            while (s_axi_rvalid !== 1'h1) @(posedge core_clk);
            // Late rready: the answer must stand through one stall
            s_axi_rready <= 1'h1;
            @(posedge core_clk);
            s_axi_rready <= 1'h0;
            chk("rvalid", 32'h0000_0001, {31'h0, s_axi_rvalid});
            chk("rdata", e, s_axi_rdata);
            chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        end
    endtask

    task wc(input [13:0] a, input [31:0] v);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            @(posedge core_clk);
            while (s_axi_bvalid !== 1'h1) begin
                if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
                if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
                @(posedge core_clk);
            end
            // Late bready: the answer must stand through one stall
            s_axi_bready <= 1'h1;
            @(posedge core_clk);
            s_axi_bready <= 1'h0;
            chk("bvalid", 32'h0000_0001, {31'h0, s_axi_bvalid});
            chk("bresp", 32'h0000_0002, {30'h0, s_axi_bresp});
        end
    endtask

    task rv(input integer k);
        begin
            rc({idx[k], 2'h0}, val(k), 2'h0);
            rc({idx[k], 2'h0}, val(k), 2'h0);
        end
    endtask

    task give_verdict;
        begin
            if (failures == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        srst <= 1'h0;
        for (i = 0; i < 12; i = i + 1) rc({idx[i], 2'h0}, 0, 2'h0);
        rc(14'h0000, 0, 2'h2);
        rc({idx[0], 2'h2}, 0, 2'h2);
        for (i = 0; i < 12; i = i + 1) begin
            wc({idx[i], 2'h0}, ~val(i));
            rc({idx[i], 2'h0}, 0, 2'h0);
        end
        // Selects 12 and 13 must leave every word untouched
        for (i = 0; i < 14; i = i + 1) begin
            upd_valid <= 1'h1;
            upd_sel <= i[3:0];
            upd_data <= val(i);
            @(posedge core_clk);
        end
        upd_valid <= 1'h0;
        for (i = 0; i < 4; i = i + 1) rv(i);
        for (i = 4; i < 8; i = i + 1) rv(i);
        for (i = 8; i < 12; i = i + 1) rv(i);
        wc({idx[11], 2'h0}, 32'h0000_0000);
        rv(11);
        srst <= 1'h1;
        repeat (2) @(posedge core_clk);
        srst <= 1'h0;
        for (i = 0; i < 12; i = i + 1) rc({idx[i], 2'h0}, 0, 2'h0);
        give_verdict;
    end

    initial begin
        #200000;
        failures = failures + 1;
        give_verdict;
    end
endmodule
